// file: design/e1_perf_counter_signaling_map.sv
// E1 counter snapshot map and extracted-signaling bank behind an indirect port.
// Assumes framer events are one-cycle pulses on mclk and the host polls busy.
`timescale 1ns/1ps
`include "e1_perf_map.svh"
module e1_perf_counter_signaling_map
    import e1_perf_pkg::*;
#(
    parameter int unsigned ONE_SEC_CYCLES = `ONE_SEC_CYCLES_DEF
)
(
    input  wire logic          mclk,           // System clock, 40 MHz
    input  wire logic          rst_n,          // Synchronous reset, active low
    input  wire logic          ctrlWrite,      // Pulse: access control written
    input  wire logic [7:0]    ctrlByte,       // Bit 7 read_write_flag, 6:0 address
    input  wire logic          spaceSelect,    // 0 counter map, 1 signaling bank
    input  wire logic          dataWrite,      // Pulse: access data written
    input  wire logic [7:0]    dataIn,         // indirect_data_byte from host
    input  wire logic          manualUpdate,   // manual_snapshot_update level
    input  wire logic          autoUpdate,     // auto_snapshot_update level
    input  wire error_events_s errEvents,      // Error event pulses
    input  wire sig_sample_s   sigIn,          // Received ABCD codeword
    input  wire logic          multiframeSync, // Signaling multiframe in sync
    output logic     [7:0]     dataOut,        // indirect_data_byte to host
    output logic               busy            // Indirect access in progress
);

    // Counter snapshots, index order as counter_id_e
    // Kept 16 wide; narrow ones zero-extended
    logic [15:0] snaps [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] eventVec;
    logic        snapPulse;

    // Update control
    // One pulse for all, so bytes agree
    logic        manualPrev;
    logic        next_manualPrev;
    logic [31:0] secCount;
    logic [31:0] next_secCount;
    logic        secTick;

    // Signaling bank
    // Indexed by slot, equal to address
    logic [3:0]  sigBits   [32];
    logic        sigEnable [32];
    logic [3:0]  next_sigBits   [32];
    logic        next_sigEnable [32];

    // Access engine
    // waitCount spaces latch and answer
    access_state_e accState;
    access_state_e next_accState;
    access_req_s   req;
    access_req_s   next_req;
    logic [2:0]    waitCount;
    logic [2:0]    next_waitCount;
    logic [7:0]    next_dataOut;
    logic          next_busy;

    // Slot 0 and 16 carry framing and multiframe words, not signaling
    // Addresses past the last slot too
    function automatic logic sig_slot_valid(input logic [6:0] addr);
        sig_slot_valid = (addr <= `SIG_ADDR_LAST)
                      && (addr[4:0] != `SIG_HOLE_ZERO)
                      && (addr[4:0] != `SIG_HOLE_MID);
    endfunction : sig_slot_valid

    // Byte view of the counter snapshots; unused bits read zero
    // Counter space above 0f reads zero as well
    function automatic logic [7:0] counter_byte(input logic [6:0] addr);
        logic [7:0] b;
        b = 8'h00;

        case (addr)
            `ADDR_CRC4_LOW:       b = snaps[CNT_CRC4][7:0];
            `ADDR_CRC4_HIGH:      b = {2'h0, snaps[CNT_CRC4][9:8], 4'h0};
            `ADDR_FRAMING_LOW:    b = snaps[CNT_FRAMING][7:0];
            `ADDR_FRAMING_HIGH:   b = {4'h0, snaps[CNT_FRAMING][11:8]};
            `ADDR_ALIGN_CHANGE:   b = {5'h00, snaps[CNT_ALIGN][2:0]};
            `ADDR_FRAME_LOSS:     b = {3'h0, snaps[CNT_LOSS][4:0]};
            `ADDR_PATTERN_LOW:    b = snaps[CNT_PATTERN][7:0];
            `ADDR_PATTERN_HIGH:   b = snaps[CNT_PATTERN][15:8];
            `ADDR_LINE_CODE_LOW:  b = snaps[CNT_LINE_CODE][7:0];
            `ADDR_LINE_CODE_HIGH: b = snaps[CNT_LINE_CODE][15:8];
            `ADDR_NEAR_CRC_LOW:   b = snaps[CNT_NEAR_CRC][7:0];
            `ADDR_NEAR_CRC_HIGH:  b = {2'h0, snaps[CNT_NEAR_CRC][9:8], 4'h0};
            `ADDR_FAR_BLOCK_LOW:  b = snaps[CNT_FAR_BLOCK][7:0];
            `ADDR_FAR_BLOCK_HIGH: b = {2'h0, snaps[CNT_FAR_BLOCK][9:8], 4'h0};
            `ADDR_NEAR_FAR_LOW:   b = snaps[CNT_NEAR_FAR][7:0];
            `ADDR_NEAR_FAR_HIGH:  b = {2'h0, snaps[CNT_NEAR_FAR][9:8], 4'h0};
            default:              b = 8'h00;
        endcase
        counter_byte = b;
    endfunction : counter_byte

    // Flatten the event struct in counter index order
    // Bit i feeds counter i
    assign eventVec = {errEvents.nearFarBlock, errEvents.farBlockError,
                       errEvents.nearCrcError, errEvents.lineCodeError,
                       errEvents.patternBitError, errEvents.frameLoss,
                       errEvents.alignmentChange, errEvents.framingError,
                       errEvents.crc4Error};

    // One live counter and snapshot per error source
    // Shared update pulse and reset
    for (genvar i = 0; i < NUM_COUNTERS; i++)
    begin : g_counter
        localparam int W = counter_width(i);
        logic [W-1:0] snapNarrow;

        error_counter #(.WIDTH(W)) u_counter
        (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .event_in (eventVec[i]),
            .update   (snapPulse),
            .snapshot (snapNarrow)
        );

        assign snaps[i] = 16'(snapNarrow);
    end

    // Group update: manual rising edge or the one-second tick in auto mode
    // Both at once give one snapshot
    // A held level pulses only once
    assign secTick   = autoUpdate && (secCount == ONE_SEC_CYCLES - 1);
    assign snapPulse = (manualUpdate && !manualPrev) || secTick;

    // Next values of the update timer and edge detector
    // Timer rests at zero while auto is off,
    // so the first tick is a full period on
    always_comb
    begin
        next_manualPrev = manualUpdate;
        next_secCount   = secCount;

        if (!autoUpdate || secTick)
        begin
            next_secCount = 32'h0;
        end
        else
        begin
            next_secCount = secCount + 32'h1;
        end
    end

    // Update timer registers
    // Detector resets to the idle level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            manualPrev <= 1'b0;
            secCount   <= 32'h0;
        end
        else
        begin
            manualPrev <= next_manualPrev;
            secCount   <= next_secCount;
        end
    end

    // Next signaling bank; host enable write and extraction touch different bits
    // Disabled slots keep their last codeword
    always_comb
    begin
        for (int s = 0; s < 32; s++)
        begin
            next_sigBits[s]   = sigBits[s];
            next_sigEnable[s] = sigEnable[s];
        end

        if (sigIn.valid && multiframeSync
            && sig_slot_valid({2'h0, sigIn.slot}) && sigEnable[sigIn.slot])
        begin
            next_sigBits[sigIn.slot] = sigIn.bits;
        end

        if (accState == ACC_DONE && req.signalingSpace && !req.readNotWrite
            && sig_slot_valid(req.address))
        begin
            next_sigEnable[req.address[4:0]] = dataOut[`SIG_ENABLE_POS];
        end
    end

    // Signaling bank registers
    // Holes reset enabled; never read
    always_ff @(posedge mclk)
    begin
        for (int s = 0; s < 32; s++)
        begin
            if (!rst_n)
            begin
                sigBits[s]   <= `SIG_BITS_RESET;
                sigEnable[s] <= `SIG_ENABLE_RESET;
            end
            else
            begin
                sigBits[s]   <= next_sigBits[s];
                sigEnable[s] <= next_sigEnable[s];
            end
        end
    end

    // Next state of the indirect access engine
    // Latch, then two waits, then the answer,
    // and busy is seen from the next cycle
    always_comb
    begin
        next_accState  = accState;
        next_req       = req;
        next_waitCount = waitCount;
        next_dataOut   = dataOut;
        next_busy      = busy;

        unique case (accState)
            ACC_IDLE:
            begin
                // Data register is writable only while idle
                if (dataWrite && !ctrlWrite)
                begin
                    next_dataOut = dataIn;
                end

                if (ctrlWrite)
                begin
                    next_req.signalingSpace = spaceSelect;
                    next_req.readNotWrite   = ctrlByte[`CTRL_RWN_POS];
                    next_req.address        = ctrlByte[6:0];
                    next_waitCount          = 3'h0;
                    next_busy               = 1'b1;
                    next_accState           = ACC_WAIT;
                end
            end

            ACC_WAIT:
            begin
                // Host strobes are ignored here; the host must wait on busy
                // keeping the latched request
                if (waitCount == `ACCESS_WAIT - 3'h1)
                begin
                    next_accState = ACC_DONE;
                end
                else
                begin
                    next_waitCount = waitCount + 3'h1;
                end
            end

            ACC_DONE:
            begin
                // Writes land the enable bit here
                if (req.readNotWrite)
                begin
                    if (!req.signalingSpace)
                    begin
                        next_dataOut = counter_byte(req.address);
                    end
                    else if (sig_slot_valid(req.address))
                    begin
                        next_dataOut = {3'h0, sigEnable[req.address[4:0]],
                                        sigBits[req.address[4:0]]};
                    end
                    else
                    begin
                        // Holes answer zero
                        next_dataOut = 8'h00;
                    end
                end

                next_busy     = 1'b0;
                next_accState = ACC_IDLE;
            end

            default:
            begin
                next_busy     = 1'b0;
                next_accState = ACC_IDLE;
            end
        endcase
    end

    // Access engine registers
    // Request stays latched until next command
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            accState  <= ACC_IDLE;
            req       <= '0;
            waitCount <= 3'h0;
            dataOut   <= `DATA_RESET;
            busy      <= 1'b0;
        end
        else
        begin
            accState  <= next_accState;
            req       <= next_req;
            waitCount <= next_waitCount;
            dataOut   <= next_dataOut;
            busy      <= next_busy;
        end
    end

endmodule : e1_perf_counter_signaling_map

// file: design/e1_perf_map.svh
// Offsets, field positions, reset values and timing counts for the E1 counter map
// and extracted-signaling bank. Assumes a 40 MHz system clock.
// Notes on behaviour
// - CRC-4 error count is 10 bits: low byte at 00, top bits 5:4 at 01.
// - Framing pattern error count is 12 bits: low byte 02, upper nibble 03 bits 3:0.
// - Alignment position change count is a 3-bit field at 04.
// - Frame synchronisation loss count is a 5-bit field at 05, low bits 4:0.
// - Pattern detector bit error count is 16 bits at 06 (low) and 07 (high).
// - Line code error count is 16 bits at 08/09, violations in AMI or HDB3.
// - Near-end CRC error count is 10 bits: low byte 0A, top bits 5:4 of 0B.
// - Far-end block error count is 10 bits: low byte 0C, top bits 5:4 of 0D.
// - Near-end far-end-block count is 10 bits: low byte 0E, top bits 5:4 of 0F.
// - One signaling register per timeslot at 01-0F and 11-1F.
// - Bit 4 extraction enable resets to 1; enabled slots copy ABCD into bits 3:0.
// - Extraction updates happen only while the signaling multiframe is synchronised.
// - A 0-to-1 edge on manual update refreshes all snapshots together.
// - With automatic update set, all snapshots refresh once every second.
// - Busy is reported during an access; host waits for busy to clear.
`ifndef E1_PERF_MAP_SVH
`define E1_PERF_MAP_SVH

`define ADDR_CRC4_LOW        7'h00
`define ADDR_CRC4_HIGH       7'h01
`define ADDR_FRAMING_LOW     7'h02
`define ADDR_FRAMING_HIGH    7'h03
`define ADDR_ALIGN_CHANGE    7'h04
`define ADDR_FRAME_LOSS      7'h05
`define ADDR_PATTERN_LOW     7'h06
`define ADDR_PATTERN_HIGH    7'h07
`define ADDR_LINE_CODE_LOW   7'h08
`define ADDR_LINE_CODE_HIGH  7'h09
`define ADDR_NEAR_CRC_LOW    7'h0a
`define ADDR_NEAR_CRC_HIGH   7'h0b
`define ADDR_FAR_BLOCK_LOW   7'h0c
`define ADDR_FAR_BLOCK_HIGH  7'h0d
`define ADDR_NEAR_FAR_LOW    7'h0e
`define ADDR_NEAR_FAR_HIGH   7'h0f

// Signaling slots: 1..15 and 17..31, slot number equals address
`define SIG_ADDR_LAST        7'h1f
`define SIG_HOLE_ZERO        5'h00
`define SIG_HOLE_MID         5'h10

// Field positions
`define TEN_BIT_HIGH_POS     4
`define SIG_ENABLE_POS       4
`define CTRL_RWN_POS         7

// Reset values
`define SNAPSHOT_RESET       16'h0000
`define SIG_ENABLE_RESET     1'b1
`define SIG_BITS_RESET       4'h0
`define DATA_RESET           8'h00

// Timing
`define CLK_KHZ              40000
`define UPDATE_PERIOD_MS     1000
`define ONE_SEC_CYCLES_DEF   (`UPDATE_PERIOD_MS * `CLK_KHZ)
`define ACCESS_WAIT          3'h2

`endif

// file: design/e1_perf_pkg.sv
// Types shared by the E1 counter map and its counter leaf.
// Assumes the header of constants is included by the files that need offsets.
package e1_perf_pkg;

    localparam int NUM_COUNTERS = 9;

    // Counter order, index 0 first
    typedef enum logic [3:0]
    {
        CNT_CRC4      = 4'h0,
        CNT_FRAMING   = 4'h1,
        CNT_ALIGN     = 4'h2,
        CNT_LOSS      = 4'h3,
        CNT_PATTERN   = 4'h4,
        CNT_LINE_CODE = 4'h5,
        CNT_NEAR_CRC  = 4'h6,
        CNT_FAR_BLOCK = 4'h7,
        CNT_NEAR_FAR  = 4'h8
    } counter_id_e;

    // One-cycle event pulses from framer, decoder and pattern detector
    typedef struct packed
    {
        logic nearFarBlock;
        logic farBlockError;
        logic nearCrcError;
        logic lineCodeError;
        logic patternBitError;
        logic frameLoss;
        logic alignmentChange;
        logic framingError;
        logic crc4Error;
    } error_events_s;

    // One received ABCD codeword
    typedef struct packed
    {
        logic       valid;
        logic [4:0] slot;
        logic [3:0] bits;
    } sig_sample_s;

    // Latched indirect command
    typedef struct packed
    {
        logic       signalingSpace;
        logic       readNotWrite;
        logic [6:0] address;
    } access_req_s;

    typedef enum logic [1:0]
    {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_DONE = 2'b11
    } access_state_e;

    function automatic int counter_width(input int idx);
        case (idx)
            0, 6, 7, 8: counter_width = 10;
            1:          counter_width = 12;
            2:          counter_width = 3;
            3:          counter_width = 5;
            default:    counter_width = 16;
        endcase
    endfunction : counter_width

endpackage : e1_perf_pkg

// file: design/error_counter.sv
// Live error counter with a snapshot copy taken on a group update.
// Assumes the event and update inputs are synchronous one-cycle pulses.
`timescale 1ns/1ps
`include "e1_perf_map.svh"
module error_counter
    import e1_perf_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             mclk,     // System clock
    input  wire logic             rst_n,    // Synchronous reset, active low
    input  wire logic             event_in, // Error event pulse
    input  wire logic             update,   // Group snapshot pulse
    output logic      [WIDTH-1:0] snapshot  // Frozen count seen by the host
);

    logic [WIDTH-1:0] live;
    logic [WIDTH-1:0] next_live;
    logic [WIDTH-1:0] next_snapshot;
    logic             atTop;

    // Saturate rather than wrap so a full count is never mistaken for a small one
    assign atTop = &live;

    // Next live and snapshot values
    always_comb
    begin
        next_live     = live;
        next_snapshot = snapshot;
        if (update)
        begin
            next_snapshot = live;
            next_live     = WIDTH'(event_in);
        end
        else if (event_in && !atTop)
        begin
            next_live = live + WIDTH'(1);
        end
    end

    // Registers; snapshot holds zero until the first update
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            live     <= '0;
            snapshot <= WIDTH'(`SNAPSHOT_RESET);
        end
        else
        begin
            live     <= next_live;
            snapshot <= next_snapshot;
        end
    end

endmodule : error_counter

// file: verif/e1_perf_asserts.sv
// Port checks for the indirect access of the counter map and signaling bank.
// Assumes read data lands at the edge where busy falls, three cycles on.
`timescale 1ns/1ps
module e1_perf_asserts
(
    input wire logic       mclk,        // System clock
    input wire logic       rst_n,       // Synchronous reset, active low
    input wire logic       ctrlWrite,   // Command pulse
    input wire logic [7:0] ctrlByte,    // Flag and address
    input wire logic       spaceSelect, // Space select
    input wire logic       dataWrite,   // Data load pulse
    input wire logic [7:0] dataIn,      // Data byte in
    input wire logic [7:0] dataOut,     // Data byte out
    input wire logic       busy         // Access in progress
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Command accepted while idle
    sequence cmdTaken;
        ctrlWrite && !busy;
    endsequence
    // Read command of one address in one space
    sequence readOf(logic [6:0] a, logic s);
        cmdTaken ##0 (ctrlByte == {1'b1, a}) && (spaceSelect == s);
    endsequence
    // Bits outside a field must read back as zero
    property zeroOutside(logic [6:0] a, logic s, logic [7:0] m);
        readOf(a, s) |-> ##4 (dataOut & m) == 8'h00;
    endproperty

    chk_busy_start: assert property (cmdTaken |=> busy)
        else $error("busy did not rise after a command");
    chk_busy_window: assert property ($rose(busy) |-> busy[*3] ##1 !busy)
        else $error("busy window not three cycles");
    chk_busy_cause: assert property ($rose(busy) |-> $past(ctrlWrite))
        else $error("busy rose without a command");
    chk_idle_hold: assert property (!busy && !ctrlWrite |=> !busy)
        else $error("busy rose while idle");
    chk_data_load: assert property (dataWrite && !ctrlWrite && !busy |=> dataOut == $past(dataIn))
        else $error("data byte not loaded");
    chk_data_steady: assert property (busy && $past(busy) |-> $stable(dataOut))
        else $error("data byte moved during access");
    chk_idle_data: assert property (!busy && !dataWrite && !ctrlWrite |=> $stable(dataOut))
        else $error("data byte moved while idle");
    chk_crc_high: assert property (zeroOutside(7'h01, 1'b0, 8'hcf))
        else $error("crc high byte has stray bits");
    chk_framing_high: assert property (zeroOutside(7'h03, 1'b0, 8'hf0))
        else $error("framing high byte has stray bits");
    chk_align_field: assert property (zeroOutside(7'h04, 1'b0, 8'hf8))
        else $error("alignment field has stray bits");
    chk_loss_field: assert property (zeroOutside(7'h05, 1'b0, 8'he0))
        else $error("loss field has stray bits");
    chk_near_high: assert property (zeroOutside(7'h0b, 1'b0, 8'hcf))
        else $error("near crc high byte has stray bits");
    chk_far_high: assert property (zeroOutside(7'h0d, 1'b0, 8'hcf))
        else $error("far block high byte has stray bits");
    chk_nearfar_high: assert property (zeroOutside(7'h0f, 1'b0, 8'hcf))
        else $error("near far high byte has stray bits");
    chk_slot_hole: assert property (zeroOutside(7'h10, 1'b1, 8'hff))
        else $error("slot 16 reads nonzero");
    chk_slot_upper: assert property (zeroOutside(7'h01, 1'b1, 8'he0))
        else $error("signaling upper bits nonzero");
endmodule : e1_perf_asserts

bind e1_perf_counter_signaling_map e1_perf_asserts u_chk
(
    .mclk(mclk), .rst_n(rst_n), .ctrlWrite(ctrlWrite), .ctrlByte(ctrlByte),
    .spaceSelect(spaceSelect), .dataWrite(dataWrite), .dataIn(dataIn),
    .dataOut(dataOut), .busy(busy)
);

// file: verif/e1_perf_counter_signaling_map_tb_top.sv
// Self-checking bench for the E1 counter map and signaling bank.
// Assumes a shortened one-second period so automatic updates fit the run.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module e1_perf_counter_signaling_map_tb_top import e1_perf_pkg::*;;
    localparam int unsigned SEC = 50; // Short period keeps the run small
    logic mclk, rst_n, ctrlWrite, spaceSelect, dataWrite, manualUpdate, autoUpdate, multiframeSync, busy;
    logic [7:0] ctrlByte, dataIn, dataOut;
    error_events_s errEvents;
    sig_sample_s   sigIn;
    logic [15:0]   cnt [9];
    int num_errors = 0;
    int compares = 0;

    e1_perf_counter_signaling_map #(.ONE_SEC_CYCLES(SEC)) u_dut
    (
        .mclk(mclk), .rst_n(rst_n), .ctrlWrite(ctrlWrite), .ctrlByte(ctrlByte),
        .spaceSelect(spaceSelect), .dataWrite(dataWrite), .dataIn(dataIn),
        .manualUpdate(manualUpdate), .autoUpdate(autoUpdate), .errEvents(errEvents),
        .sigIn(sigIn), .multiframeSync(multiframeSync), .dataOut(dataOut), .busy(busy)
    );
    host_model u_host
    (
        .mclk(mclk), .busy(busy), .dataOut(dataOut), .ctrlWrite(ctrlWrite), .ctrlByte(ctrlByte),
        .spaceSelect(spaceSelect), .dataWrite(dataWrite), .dataIn(dataIn)
    );

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_sim();
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // One host access; a hung access ends the run
    task automatic acc(input logic r, input logic [6:0] a, input logic s,
                       input logic [7:0] w, output logic [7:0] d);
        logic ok;
        u_host.access(r, a, s, w, d, ok);
        if (!ok)
        begin
            num_errors++;
            end_sim();
        end
    endtask : acc

    // One cycle of event pulses with the manual update level
    task automatic pulse(input logic [8:0] ev, input logic up);
        @(posedge mclk);
        #1;
        errEvents    = ev;
        manualUpdate = up;
    endtask : pulse

    // Byte layout of each snapshot address
    function automatic logic [7:0] exp_byte(input int a);
        logic [15:0] c;
        c = cnt[a < 4 ? a / 2 : (a < 6 ? a - 2 : a / 2 + 1)];
        if (a % 2 == 0 || a == 5)
            exp_byte = c[7:0];
        else if (a == 3)
            exp_byte = {4'h0, c[11:8]};
        else if (a == 7 || a == 9)
            exp_byte = c[15:8];
        else
            exp_byte = {2'b00, c[9:8], 4'h0};
    endfunction : exp_byte

    task automatic check_all();
        logic [7:0] d;
        for (int a = 0; a < 16; a++)
        begin
            acc(1'b1, a[6:0], 1'b0, 8'h00, d);
            `CHK("snapshot", exp_byte(a), d)
        end
    endtask : check_all

    task automatic t_reset_values();
        logic [7:0] d;
        for (int a = 0; a < 32; a++)
        begin
            acc(1'b1, a[6:0], 1'b0, 8'h00, d);
            `CHK("snapshot reset", 8'h00, d)
            acc(1'b1, a[6:0], 1'b1, 8'h00, d);
            `CHK("slot reset", (a % 16 == 0) ? 8'h00 : 8'h10, d)
        end
    endtask : t_reset_values

    // Counts reach the high bytes; an event in the update cycle must survive
    task automatic t_counters();
        logic [8:0] ev;
        logic [7:0] d;
        cnt = '{16'd260, 16'd275, 16'd5, 16'd20, 16'd290, 16'd257, 16'd270, 16'd280, 16'd299};
        for (int k = 0; k < 300; k++)
        begin
            for (int i = 0; i < 9; i++)
                ev[i] = (k < cnt[i]);
            pulse(ev, 1'b0);
        end
        pulse(9'h001, 1'b1);
        pulse(9'h000, 1'b1);
        check_all();
        pulse(9'h001, 1'b0);
        pulse(9'h001, 1'b0);
        pulse(9'h000, 1'b0);
        acc(1'b1, 7'h00, 1'b0, 8'h00, d);
        `CHK("held snapshot", 8'h04, d)
        pulse(9'h000, 1'b1);
        pulse(9'h000, 1'b0);
        cnt = '{16'd3, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0};
        check_all();
    endtask : t_counters

    task automatic t_auto();
        logic [7:0] d;
        pulse(9'h020, 1'b0);
        pulse(9'h000, 1'b0);
        autoUpdate = 1'b1;
        acc(1'b1, 7'h08, 1'b0, 8'h00, d);
        `CHK("before auto", 8'h00, d)
        repeat (SEC) @(posedge mclk);
        acc(1'b1, 7'h08, 1'b0, 8'h00, d);
        `CHK("after auto", 8'h01, d)
        autoUpdate = 1'b0;
    endtask : t_auto

    // One received codeword; the bus then shows the inverse
    task automatic sig(input logic [4:0] slot, input logic [3:0] b);
        @(posedge mclk);
        #1;
        sigIn = '{1'b1, slot, b};
        @(posedge mclk);
        #1;
        sigIn = '{1'b0, ~slot, ~b};
    endtask : sig

    task automatic t_extract();
        logic [7:0] d;
        acc(1'b0, 7'h05, 1'b1, 8'h00, d);
        acc(1'b0, 7'h10, 1'b1, 8'h1f, d);
        sig(5'd3, 4'ha);
        acc(1'b1, 7'h03, 1'b1, 8'h00, d);
        `CHK("no sync", 8'h10, d)
        multiframeSync = 1'b1;
        sig(5'd3, 4'ha);
        sig(5'd5, 4'h6);
        sig(5'd31, 4'h5);
        acc(1'b1, 7'h03, 1'b1, 8'h00, d);
        `CHK("slot 3", 8'h1a, d)
        acc(1'b1, 7'h05, 1'b1, 8'h00, d);
        `CHK("slot 5 off", 8'h00, d)
        acc(1'b1, 7'h1f, 1'b1, 8'h00, d);
        `CHK("slot 31", 8'h15, d)
        acc(1'b1, 7'h10, 1'b1, 8'h00, d);
        `CHK("slot 16", 8'h00, d)
        acc(1'b0, 7'h05, 1'b1, 8'hff, d);
        acc(1'b1, 7'h05, 1'b1, 8'h00, d);
        `CHK("slot 5 on", 8'h10, d)
    endtask : t_extract

    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_sim();
    end

    initial
    begin
        rst_n          = 1'b0;
        manualUpdate   = 1'b0;
        autoUpdate     = 1'b0;
        multiframeSync = 1'b0;
        errEvents      = '0;
        sigIn          = '0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset_values();
        t_counters();
        t_auto();
        t_extract();
        end_sim();
    end
endmodule : e1_perf_counter_signaling_map_tb_top

// file: verif/host_model.sv
// Host processor model driving the indirect access port of the counter map.
// Assumes the map answers each command within a few cycles by dropping busy.
`timescale 1ns/1ps
module host_model
(
    input  wire logic       mclk,        // System clock
    input  wire logic       busy,        // Access in progress
    input  wire logic [7:0] dataOut,     // Data register readback
    output logic            ctrlWrite,   // Command pulse
    output logic      [7:0] ctrlByte,    // Flag and address
    output logic            spaceSelect, // Counter map or signaling bank
    output logic            dataWrite,   // Data load pulse
    output logic      [7:0] dataIn       // Data byte
);
    // Quiet port at time zero
    initial
    begin
        ctrlWrite   = 1'b0;
        ctrlByte    = 8'h00;
        spaceSelect = 1'b0;
        dataWrite   = 1'b0;
        dataIn      = 8'h00;
    end

    // One access; released lines carry the inverse so stale values never pass
    task automatic access(input logic r, input logic [6:0] a, input logic s,
                          input logic [7:0] w, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        #1;
        if (!r)
        begin
            dataWrite = 1'b1;
            dataIn    = w;
            @(posedge mclk);
            #1;
            dataWrite = 1'b0;
            dataIn    = ~w;
        end
        ctrlWrite   = 1'b1;
        ctrlByte    = {r, a};
        spaceSelect = s;
        @(posedge mclk);
        #1;
        ctrlWrite   = 1'b0;
        ctrlByte    = ~ctrlByte;
        spaceSelect = ~s;
        ok          = 1'b0;
        // Bounded poll: a stuck busy is reported, not waited on forever
        for (int n = 0; n < 8 && !ok; n++)
        begin
            @(posedge mclk);
            #1;
            ok = !busy;
        end
        d = dataOut;
    endtask : access
endmodule : host_model
